// ===== common/modbus_fmt_pkg.sv
// Constants for the Modbus sub device formatter: register map, fields, resets, timing
// Used by the top module; no other package is assumed
package modbus_fmt_pkg;
  // Timing
  localparam int CLK_HZ            = 25_000_000;
  localparam int DELAY_UNIT_MS     = 1;
  localparam int CYCLES_PER_MS_DEF = CLK_HZ / 1000 * DELAY_UNIT_MS;
  localparam int PT_DEPTH_DEF      = 64;
  // First value register number (20000)
  localparam logic [15:0] REG_BASE = 16'h4E20;
  // Register word indexes, byte address is four times the index
  localparam logic [5:0] IX_CTRL   = 6'h00;
  localparam logic [5:0] IX_STAT   = 6'h01;
  localparam logic [5:0] IX_PORT   = 6'h02;
  localparam logic [5:0] IX_BAUD   = 6'h03;
  localparam logic [5:0] IX_DELAY  = 6'h04;
  localparam logic [5:0] IX_ERRF   = 6'h05;
  localparam logic [5:0] IX_ERRI   = 6'h06;
  localparam logic [5:0] IX_SMAX   = 6'h07;
  localparam logic [5:0] IX_GAIN   = 6'h08;
  localparam logic [5:0] IX_OFS    = 6'h09;
  localparam logic [5:0] IX_PTIDX  = 6'h0A;
  localparam logic [5:0] IX_PTLO   = 6'h0B;
  localparam logic [5:0] IX_PTHI   = 6'h0C;
  localparam logic [5:0] IX_STATUS = 6'h0D;
  // Control register fields
  localparam int CB_SINGLE = 0;
  localparam int CB_PAR    = 1;
  localparam int CB_TWO    = 3;
  localparam int CB_UNMAP  = 4;
  localparam int CB_REPR   = 5;
  localparam int CB_SWAP   = 7;
  localparam int CB_STERR  = 8;
  localparam int CB_FERR   = 9;
  localparam int CB_GLOBAL = 11;
  // Reset values
  localparam logic [11:0] CTRL_RST    = 12'h803;
  localparam logic [7:0]  STATION_RST = 8'h01;
  localparam logic [15:0] PORT_RST    = 16'h01F6;
  localparam logic [15:0] BAUD_RST    = 16'h0A2C;
  localparam logic [15:0] DELAY_RST   = 16'h0000;
  localparam logic [15:0] SMAX_RST    = 16'hFFFE;
  localparam logic [11:0] GAIN_RST    = 12'h100;
  // Encodings
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] REPR_FLOAT = 2'h0;
  localparam logic [1:0] REPR_ROUND = 2'h1;
  localparam logic [1:0] REPR_SCALED = 2'h2;
  localparam logic [1:0] FERR_NAN  = 2'h0;
  localparam logic [1:0] FERR_PINF = 2'h1;
  localparam logic [1:0] FERR_NINF = 2'h2;
  localparam logic [31:0] FLT_NAN  = 32'h7FC00000;
  localparam logic [31:0] FLT_PINF = 32'h7F800000;
  localparam logic [31:0] FLT_NINF = 32'hFF800000;
  localparam logic [7:0]  FLT_EXP_ADJ = 8'h6F;
  localparam logic [15:0] SCALE_MAX_MIN = 16'h03E7;
  localparam logic [15:0] SCALE_MAX_MAX = 16'hFFFE;
  localparam logic [23:0] SCALE_BIAS = 24'h008000;
  localparam logic [7:0]  EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [3:0]  FRAME_BASE_BITS = 4'hA;
  // Point entry layout
  localparam int PT_W        = 62;
  localparam int PT_OFS_LSB  = 32;
  localparam int PT_GAIN_LSB = 48;
  localparam int PT_ERR      = 60;
  localparam int PT_MAP      = 61;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_FETCH = 5'b00010,
    ST_DELAY = 5'b00100,
    ST_SEND  = 5'b01000,
    ST_RESP  = 5'b10000
  } state_type;
endpackage : modbus_fmt_pkg

// ===== src/point_ram.sv
// Point table storage: one write port, one registered read port
// Assumes writer and reader share one clock; unwritten entries read as zero
`timescale 1ns/1ps
module point_ram #(
  parameter int WIDTH = 62,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data_q
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [DEPTH-1:0] vld_q;

  // Storage array, no reset
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Written flags, so a fresh table reads as empty
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vld_q <= '0;
    end else if (wr_en) begin
      vld_q[wr_addr] <= 1'b1;
    end
  end

  // Registered read data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= '0;
    end else if (rd_en) begin
      rd_data_q <= vld_q[rd_addr] ? mem_q[rd_addr] : '0;
    end
  end
endmodule : point_ram

// ===== src/modbus_sub_device_value_formatter.sv
// Modbus sub device front end: config registers, point table, value formatter, RTU serializer
// Assumes requests parsed upstream on hclk, one AHB-Lite master, RS-485 driver outside
//
// Summary of operation
// - Answers polls only, never starts traffic
// - Single-address mode answers one station only on RTU requests
// - TCP requests need the configured port
// - Serial bit time from configured baud divisor
// - Parity none, even or odd per character
// - One or two stop bits per character
// - Wait configured milliseconds before RTU answer
// - Unmapped read gives zeros or exception
// - Float mode sends 32-bit float
// - Round mode sends nearest whole number
// - Scaled equals gain times value, offset, 32768
// - Swap reverses float word order only
// - Source error substitutes configured error value
// - Float error: NaN, +Inf, -Inf, user
// - Integer error value is user integer
// - Scaled maximum limited to 999..65534
// - Global or per point gain and offset
// - Gain multiplies value, offset is applied
// - Each point spans two 16-bit registers
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module modbus_sub_device_value_formatter
  import modbus_fmt_pkg::*;
#(
  parameter int DEPTH         = PT_DEPTH_DEF,
  parameter int CYCLES_PER_MS = CYCLES_PER_MS_DEF
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_is_tcp,
  input  wire logic [7:0]  req_station,
  input  wire logic [15:0] req_tcp_port,
  input  wire logic [15:0] req_reg,
  output logic             resp_valid,
  input  wire logic        resp_ready,
  output logic      [15:0] resp_word,
  output logic             resp_exc,
  output logic             rtu_txd,
  output logic             rtu_tx_en
);
  localparam int AW = $clog2(DEPTH);
  localparam int MW = $clog2(CYCLES_PER_MS + 1);

  // Bus data phase tracking
  logic        dph_wr_q;
  logic        dph_rd_q;
  logic        rd_done_q;
  logic        dph_ok_q;
  logic [5:0]  dph_ix_q;
  logic [31:0] hrdata_q;
  // Configuration registers
  logic [11:0] ctrl_q;
  logic [7:0]  station_q;
  logic [15:0] tcp_port_q;
  logic [15:0] baud_div_q;
  logic [15:0] delay_q;
  logic [31:0] err_flt_q;
  logic [16:0] err_int_q;
  logic [15:0] scale_max_q;
  logic [11:0] g_gain_q;
  logic [15:0] g_ofs_q;
  logic [AW-1:0] pt_idx_q;
  logic [31:0] pt_lo_q;
  // Engine state
  state_type   state_q;
  logic        is_tcp_q;
  logic        in_rng_q;
  logic        odd_q;
  logic [15:0] resp_word_q;
  logic        resp_exc_q;
  logic [MW-1:0] ms_cnt_q;
  logic [15:0] ms_left_q;
  logic [10:0] shift_q;
  logic [3:0]  bits_q;
  logic [15:0] baud_q;
  logic        more_q;
  logic        txd_q;
  logic [31:0] dly_cyc_q;
  logic [PT_W-1:0] pt;

  // Bus decode; reads take one wait state so hrdata comes from a flop
  wire addr_take = hsel & hready & htrans[1];
  wire wr_go     = dph_wr_q & dph_ok_q;
  wire we_ctrl   = wr_go & (dph_ix_q == IX_CTRL);
  wire we_stat   = wr_go & (dph_ix_q == IX_STAT);
  wire we_port   = wr_go & (dph_ix_q == IX_PORT);
  wire we_baud   = wr_go & (dph_ix_q == IX_BAUD);
  wire we_delay  = wr_go & (dph_ix_q == IX_DELAY);
  wire we_errf   = wr_go & (dph_ix_q == IX_ERRF);
  wire we_erri   = wr_go & (dph_ix_q == IX_ERRI);
  wire we_smax   = wr_go & (dph_ix_q == IX_SMAX);
  wire we_gain   = wr_go & (dph_ix_q == IX_GAIN);
  wire we_ofs    = wr_go & (dph_ix_q == IX_OFS);
  wire we_ptidx  = wr_go & (dph_ix_q == IX_PTIDX);
  wire we_ptlo   = wr_go & (dph_ix_q == IX_PTLO);
  wire we_pthi   = wr_go & (dph_ix_q == IX_PTHI);
  assign hreadyout = ~(dph_rd_q & ~rd_done_q);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // State decode
  wire st_idle  = (state_q == ST_IDLE);
  wire st_fetch = (state_q == ST_FETCH);
  wire st_delay = (state_q == ST_DELAY);
  wire st_send  = (state_q == ST_SEND);
  wire st_resp  = (state_q == ST_RESP);

  // Read multiplexer; unmapped words read zero
  wire [31:0] rd_mux =
    !dph_ok_q                 ? 32'h0 :
    (dph_ix_q == IX_CTRL)     ? {20'h0, ctrl_q} :
    (dph_ix_q == IX_STAT)     ? {24'h0, station_q} :
    (dph_ix_q == IX_PORT)     ? {16'h0, tcp_port_q} :
    (dph_ix_q == IX_BAUD)     ? {16'h0, baud_div_q} :
    (dph_ix_q == IX_DELAY)    ? {16'h0, delay_q} :
    (dph_ix_q == IX_ERRF)     ? err_flt_q :
    (dph_ix_q == IX_ERRI)     ? {{15{err_int_q[16]}}, err_int_q} :
    (dph_ix_q == IX_SMAX)     ? {16'h0, scale_max_q} :
    (dph_ix_q == IX_GAIN)     ? {20'h0, g_gain_q} :
    (dph_ix_q == IX_OFS)      ? {16'h0, g_ofs_q} :
    (dph_ix_q == IX_PTIDX)    ? {{(32-AW){1'b0}}, pt_idx_q} :
    (dph_ix_q == IX_PTLO)     ? pt_lo_q :
    (dph_ix_q == IX_STATUS)   ? {26'h0, state_q, ~st_idle} : 32'h0;

  // Maximum clamped into its legal span on write
  wire [15:0] smax_wr = (hwdata[15:0] < SCALE_MAX_MIN) ? SCALE_MAX_MIN :
                        (hwdata[15:0] > SCALE_MAX_MAX) ? SCALE_MAX_MAX : hwdata[15:0];

  // Address and data phase registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_q  <= 1'b0;
      dph_rd_q  <= 1'b0;
      rd_done_q <= 1'b0;
      dph_ok_q  <= 1'b0;
      dph_ix_q  <= 6'h0;
      hrdata_q  <= 32'h0;
    end else if (hready) begin
      dph_wr_q  <= addr_take & hwrite;
      dph_rd_q  <= addr_take & ~hwrite;
      dph_ok_q  <= (haddr[31:8] == 24'h0);
      dph_ix_q  <= haddr[7:2];
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= 1'b1;
      hrdata_q  <= rd_mux;
    end
  end

  // Configuration register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q      <= CTRL_RST;
      station_q   <= STATION_RST;
      tcp_port_q  <= PORT_RST;
      baud_div_q  <= BAUD_RST;
      delay_q     <= DELAY_RST;
      err_flt_q   <= FLT_NAN;
      err_int_q   <= 17'h0;
      scale_max_q <= SMAX_RST;
      g_gain_q    <= GAIN_RST;
      g_ofs_q     <= 16'h0;
      pt_idx_q    <= '0;
      pt_lo_q     <= 32'h0;
    end else begin
      if (we_ctrl)  ctrl_q      <= hwdata[11:0];
      if (we_stat)  station_q   <= hwdata[7:0];
      if (we_port)  tcp_port_q  <= hwdata[15:0];
      if (we_baud)  baud_div_q  <= (hwdata[15:0] == 16'h0) ? 16'h1 : hwdata[15:0];
      if (we_delay) delay_q     <= hwdata[15:0];
      if (we_errf)  err_flt_q   <= hwdata;
      if (we_erri)  err_int_q   <= hwdata[16:0];
      if (we_smax)  scale_max_q <= smax_wr;
      if (we_gain)  g_gain_q    <= hwdata[11:0];
      if (we_ofs)   g_ofs_q     <= hwdata[15:0];
      if (we_ptidx) pt_idx_q    <= hwdata[AW-1:0];
      if (we_ptlo)  pt_lo_q     <= hwdata;
    end
  end

  // Control fields
  wire       cfg_single = ctrl_q[CB_SINGLE];
  wire [1:0] cfg_par    = ctrl_q[CB_PAR +: 2];
  wire       cfg_two    = ctrl_q[CB_TWO];
  wire       cfg_unmap  = ctrl_q[CB_UNMAP];
  wire [1:0] cfg_repr   = ctrl_q[CB_REPR +: 2];
  wire       cfg_swap   = ctrl_q[CB_SWAP];
  wire       cfg_sterr  = ctrl_q[CB_STERR];
  wire [1:0] cfg_ferr   = ctrl_q[CB_FERR +: 2];
  wire       cfg_global = ctrl_q[CB_GLOBAL];

  // Request filter and point lookup, two registers per point
  wire [15:0] rel      = req_reg - REG_BASE;
  wire        in_range = (req_reg >= REG_BASE) & ({1'b0, rel[15:1]} < 16'(DEPTH));
  wire        accept   = req_is_tcp ? (req_tcp_port == tcp_port_q)
                                    : (~cfg_single | (req_station == station_q));
  wire        take_req = st_idle & req_valid & accept;
  assign req_ready = st_idle;

  point_ram #(
    .WIDTH (PT_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_points (
    .clk       (hclk),
    .rst_n     (hresetn),
    .wr_en     (we_pthi),
    .wr_addr   (pt_idx_q),
    .wr_data   ({hwdata[PT_W-33:0], pt_lo_q}),
    .rd_en     (st_idle & req_valid),
    .rd_addr   (rel[AW:1]),
    .rd_data_q (pt)
  );

  // Fixed point 16.16 to single precision, truncating mantissa bits past the top 24
  function automatic logic [31:0] to_float(input logic [31:0] v);
    logic [31:0] mag;
    logic [31:0] nrm;
    logic [4:0]  msb;
    mag = v[31] ? (~v + 32'h1) : v;
    msb = 5'h0;
    for (int i = 0; i < 32; i++) begin
      if (mag[i]) begin
        msb = 5'(i);
      end
    end
    nrm = mag << (5'd31 - msb);
    to_float = (mag == 32'h0) ? 32'h0 : {v[31], {3'h0, msb} + FLT_EXP_ADJ, nrm[30:8]};
  endfunction : to_float

  // Serial character: start, data LSB first, parity or stop, stop bits
  function automatic logic [11:0] frame(input logic [7:0] b, input logic [1:0] par);
    frame = {2'b11, (par == PAR_EVEN) ? ^b : (par == PAR_ODD) ? ~^b : 1'b1, b, 1'b0};
  endfunction : frame

  // Scaling: y = gain * x - (offset - 32768), then saturation
  wire        [31:0] x_val  = pt[31:0];
  wire signed [15:0] ofs    = cfg_global ? g_ofs_q : pt[PT_OFS_LSB +: 16];
  wire        [11:0] gain   = cfg_global ? g_gain_q : pt[PT_GAIN_LSB +: 12];
  wire signed [44:0] prod   = $signed(x_val) * $signed({1'b0, gain});
  wire signed [44:0] prod_r = prod + 45'sh800000;
  wire signed [23:0] a_int  = {{3{prod_r[44]}}, prod_r[44:24]};
  wire signed [23:0] y_raw  = a_int - {{8{ofs[15]}}, ofs} + SCALE_BIAS;
  wire        [15:0] y_sat  = y_raw[23] ? 16'h0 :
                              (y_raw > {8'h0, scale_max_q}) ? scale_max_q : y_raw[15:0];
  wire        [31:0] x_rnd  = x_val + 32'h0000_8000;
  wire        [31:0] rnd32  = {{16{x_rnd[31]}}, x_rnd[31:16]};
  // Error substitution
  wire        sub  = cfg_sterr & pt[PT_ERR];
  wire [31:0] ferr = (cfg_ferr == FERR_NAN)  ? FLT_NAN :
                     (cfg_ferr == FERR_PINF) ? FLT_PINF :
                     (cfg_ferr == FERR_NINF) ? FLT_NINF : err_flt_q;
  wire [31:0] fmt32 =
    (cfg_repr == REPR_FLOAT)   ? (sub ? ferr : to_float(x_val)) :
    sub                        ? {{15{err_int_q[16]}}, err_int_q} :
    (cfg_repr == REPR_ROUND)   ? rnd32 : {16'h0, y_sat};
  wire [15:0] fmt_lo   = fmt32[15:0];
  wire        hi_first = ~(cfg_swap & (cfg_repr == REPR_FLOAT));
  wire        hit      = in_rng_q & pt[PT_MAP];
  wire [15:0] word     = (odd_q ^ hi_first) ? fmt32[31:16] : fmt_lo;

  // Serializer decode
  wire [3:0] nbits    = FRAME_BASE_BITS + {3'h0, cfg_par != PAR_NONE} + {3'h0, cfg_two};
  wire       tick     = (baud_q == baud_div_q - 16'h1);
  wire       frm_end  = st_send & tick & (bits_q == 4'h0);
  wire       dly_done = st_delay & (ms_left_q == 16'h0);
  wire [7:0] next_byte = dly_done ? (resp_exc_q ? EXC_ILLEGAL_ADDR : resp_word_q[15:8])
                                  : resp_word_q[7:0];
  wire [11:0] frm     = frame(next_byte, cfg_par);
  wire       load     = dly_done | (frm_end & more_q);
  assign resp_valid = st_resp;
  assign resp_word  = resp_word_q;
  assign resp_exc   = resp_exc_q;
  assign rtu_txd    = txd_q;
  assign rtu_tx_en  = st_send;

  // Sequencer: traffic only follows an accepted request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:  if (take_req) state_q <= ST_FETCH;
        ST_FETCH: state_q <= is_tcp_q ? ST_RESP : ST_DELAY;
        ST_DELAY: if (dly_done) state_q <= ST_SEND;
        ST_SEND:  if (frm_end & ~more_q) state_q <= ST_IDLE;
        ST_RESP:  if (resp_ready) state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  // Request capture and formatted answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      is_tcp_q    <= 1'b0;
      in_rng_q    <= 1'b0;
      odd_q       <= 1'b0;
      resp_word_q <= 16'h0;
      resp_exc_q  <= 1'b0;
    end else if (take_req) begin
      is_tcp_q <= req_is_tcp;
      in_rng_q <= in_range;
      odd_q    <= req_reg[0];
    end else if (st_fetch) begin
      resp_word_q <= hit ? word : 16'h0;
      resp_exc_q  <= ~hit & cfg_unmap;
    end
  end

  // Response delay in whole milliseconds
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt_q  <= '0;
      ms_left_q <= 16'h0;
    end else if (st_fetch) begin
      ms_cnt_q  <= '0;
      ms_left_q <= delay_q;
    end else if (st_delay & ~dly_done) begin
      ms_cnt_q  <= (ms_cnt_q == MW'(CYCLES_PER_MS - 1)) ? '0 : ms_cnt_q + 1'b1;
      if (ms_cnt_q == MW'(CYCLES_PER_MS - 1)) ms_left_q <= ms_left_q - 16'h1;
    end
  end

  // Bit shifter with baud timing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_q <= 11'h7FF;
      bits_q  <= 4'h0;
      baud_q  <= 16'h0;
      more_q  <= 1'b0;
      txd_q   <= 1'b1;
    end else if (load) begin
      txd_q   <= frm[0];
      shift_q <= frm[11:1];
      bits_q  <= nbits - 4'h1;
      baud_q  <= 16'h0;
      more_q  <= dly_done & ~resp_exc_q;
    end else if (st_send) begin
      baud_q <= tick ? 16'h0 : baud_q + 16'h1;
      if (tick & (bits_q != 4'h0)) begin
        txd_q   <= shift_q[0];
        shift_q <= {1'b1, shift_q[10:1]};
        bits_q  <= bits_q - 4'h1;
      end else if (frm_end) begin
        txd_q <= 1'b1;
      end
    end
  end

  // Cycles spent waiting, read only by the delay check
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly_cyc_q <= 32'h0;
    end else begin
      dly_cyc_q <= st_delay ? dly_cyc_q + 32'h1 : 32'h0;
    end
  end

  // Checks on the answer path
  a_no_unsolicited: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(rtu_tx_en) |-> $past(st_delay))
    else $error("Serial drive began without a pending answer");
  a_station_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    st_idle && req_valid && !req_is_tcp && cfg_single && req_station != station_q |=> st_idle)
    else $error("Request for another station was taken");
  a_tcp_port_take: assert property (@(posedge hclk) disable iff (!hresetn)
    st_idle && req_valid && req_is_tcp && req_tcp_port == tcp_port_q |=> st_fetch ##1 resp_valid)
    else $error("TCP request on own port not answered in two cycles");
  a_bit_time: assert property (@(posedge hclk) disable iff (!hresetn)
    st_send && $past(st_send) && $changed(rtu_txd) |-> $past(tick))
    else $error("Serial line changed inside a bit time");
  a_parity_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_send) && cfg_par != PAR_NONE |-> (^shift_q[8:0]) == (cfg_par == PAR_ODD))
    else $error("Parity bit does not match the setting");
  a_start_frame: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_send) |-> !rtu_txd && bits_q == nbits - 4'h1)
    else $error("Character start or length wrong");
  a_delay_len: assert property (@(posedge hclk) disable iff (!hresetn)
    dly_done |-> dly_cyc_q == 32'(delay_q) * CYCLES_PER_MS)
    else $error("Response delay length wrong");
  a_unmap_answer: assert property (@(posedge hclk) disable iff (!hresetn)
    st_fetch && !hit |=> resp_word_q == 16'h0 && resp_exc_q == $past(cfg_unmap))
    else $error("Unmapped read answer wrong");
  a_swap_low: assert property (@(posedge hclk) disable iff (!hresetn)
    st_fetch && hit && cfg_repr == REPR_FLOAT && cfg_swap && !odd_q |=> resp_word_q == $past(fmt_lo))
    else $error("Swapped float did not send low word first");
  a_float_err: assert property (@(posedge hclk) disable iff (!hresetn)
    st_fetch && hit && sub && cfg_repr == REPR_FLOAT && cfg_ferr == FERR_NAN && !odd_q && !cfg_swap
    |=> resp_word_q == FLT_NAN[31:16])
    else $error("Float error value not substituted");
  a_int_err: assert property (@(posedge hclk) disable iff (!hresetn)
    st_fetch && hit && sub && cfg_repr != REPR_FLOAT && odd_q |=> resp_word_q == err_int_q[15:0])
    else $error("Integer error value not substituted");
  a_max_range: assert property (@(posedge hclk) disable iff (!hresetn)
    scale_max_q >= SCALE_MAX_MIN && scale_max_q <= SCALE_MAX_MAX)
    else $error("Scaled maximum out of range");
  a_scaled_sat: assert property (@(posedge hclk) disable iff (!hresetn)
    st_fetch && hit && !sub && cfg_repr == REPR_SCALED && odd_q |=> resp_word_q <= $past(scale_max_q))
    else $error("Scaled value above maximum");
endmodule : modbus_sub_device_value_formatter

// ===== verif/modbus_host_model.sv
// Host model: Modbus master or client polling the formatter over TCP or RTU, one request at a time
// Assumes the formatter's request/answer handshake on hclk
`timescale 1ns/1ps
module modbus_host_model (
  input  wire logic        hclk,
  output logic             req_valid,
  input  wire logic        req_ready,
  output logic             req_is_tcp,
  output logic      [7:0]  req_station,
  output logic      [15:0] req_tcp_port,
  output logic      [15:0] req_reg,
  input  wire logic        resp_valid,
  output logic             resp_ready,
  input  wire logic [15:0] resp_word,
  input  wire logic        resp_exc,
  input  wire logic        rtu_txd
);
  // Quiet host, always willing to take an answer
  initial begin
    req_valid = 0;
    {req_is_tcp, req_station, req_tcp_port, req_reg} = '1;
    resp_ready = 1;
  end
  // Only the host starts traffic; request held until req_ready is seen, then register and port scrambled
  task automatic poll(input logic tcp, input logic [7:0] st, input logic [15:0] port, input logic [15:0] rg,
                      output logic [15:0] w, output logic e, output int n);
    @(posedge hclk);
    req_valid <= 1;
    req_is_tcp <= tcp;
    req_station <= st;
    req_tcp_port <= port;
    req_reg <= rg;
    n = 0;
    do @(posedge hclk); while (req_ready !== 1'b1 && ++n < 99);
    req_valid <= 0;
    req_reg <= ~rg;
    req_tcp_port <= ~port;
    if (tcp) do @(posedge hclk); while (resp_valid !== 1'b1 && ++n < 99);
    w = resp_word;
    e = resp_exc;
  endtask : poll
  // Serial receiver: waits for a start bit, then samples nb bits mid-bit, div clocks per bit
  task automatic rx(input int div, input int nb, output logic [11:0] f, output int n);
    f = '1;
    n = 0;
    while (rtu_txd !== 1'b0 && ++n < 999) @(posedge hclk);
    repeat (div / 2) @(posedge hclk);
    for (int i = 0; i < nb; i++) begin
      f[i] = rtu_txd;
      if (i + 1 < nb) repeat (div) @(posedge hclk);
    end
  endtask : rx
endmodule : modbus_host_model

// ===== verif/modbus_sub_device_value_formatter_tb.sv
// Testbench: bus master, host model and integer model of the formatted words
// Assumes one 25 MHz clock and the formatter's hand-over timing
`timescale 1ns/1ps
module modbus_sub_device_value_formatter_tb;
  import modbus_fmt_pkg::*;
  `define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin errors++; $display("[FAIL] %s exp %h got %h", nm, e, s); end end
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, req_valid, req_ready, req_is_tcp, resp_valid;
  logic        resp_ready, resp_exc, rtu_txd, rtu_tx_en, e;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [15:0] req_tcp_port, req_reg, resp_word, w;
  logic [7:0]  req_station;
  int          errors, tests_run, n, v;
  logic [15:0] expq[$];
  logic [11:0] f;
  logic [15:0] fe[4] = '{16'h7FC0, 16'h7F80, 16'hFF80, 16'h4048};
  modbus_sub_device_value_formatter #(.CYCLES_PER_MS(4)) u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .req_valid, .req_ready, .req_is_tcp,
    .req_station, .req_tcp_port, .req_reg, .resp_valid, .resp_ready, .resp_word, .resp_exc, .rtu_txd, .rtu_tx_en);
  modbus_host_model u_host (.hclk, .req_valid, .req_ready, .req_is_tcp, .req_station, .req_tcp_port, .req_reg,
    .resp_valid, .resp_ready, .resp_word, .resp_exc, .rtu_txd);
  // Free-running clock
  initial begin
    hclk = 0;
    forever #20 hclk = ~hclk;
  end
  // Verdict and end of run
  task automatic end_sim;
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // Single word transfer, address and data phase each held until hready
  task automatic bus(input logic wr, input logic [5:0] ix, input logic [31:0] wd);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 24'h000000, ix, 2'h0};
    n = 0;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    rd = hrdata;
    if (n >= 50) begin errors++; end_sim(); end
  endtask : bus
  // Poll over TCP port 502, compare with the queued expectation
  task automatic tcp(input logic [15:0] rg, input logic [15:0] ew, input logic ee);
    expq.push_back(ew);
    u_host.poll(1'b1, 8'h01, 16'h01F6, rg, w, e, n);
    if (n >= 99) begin errors++; end_sim(); end
    ew = expq.pop_front();
    `CHK("resp_word", ew, w)
    `CHK("resp_exc", ee, e)
  endtask : tcp
  // RTU poll through the serial model; each character expected from the parity and stop settings
  task automatic rtu(input logic [11:0] c, input logic [7:0] st, input logic [15:0] rg, input logic [15:0] ew,
                     input logic ee);
    logic [11:0] x;
    logic [7:0]  b;
    int          nb;
    bus(1, IX_CTRL, 32'(c));
    u_host.poll(1'b0, st, 16'h0, rg, w, e, n);
    nb = 10 + int'(c[2:1] != 2'h0) + int'(c[3]);
    for (int i = 0; i < 2 - ee; i++) begin
      b = ee ? EXC_ILLEGAL_ADDR : ew[15 - 8 * i -: 8];
      x = {2'b11, (c[2:1] == 2'h0) ? 1'b1 : ^{b, c[2]}, b, 1'b0};
      u_host.rx(8, nb, f, n);
      if (n >= 999) begin errors++; end_sim(); end
      `CHK("rtu_frame", x, f)
      if (i == 0) `CHK("rtu_delay", 3 + 2 * 4, n)
    end
    `CHK("rtu_tx_en", 1'b1, rtu_tx_en)
    repeat (10) @(posedge hclk);
    `CHK("rtu_tx_en", 1'b0, rtu_tx_en)
  endtask : rtu
  // Main sequence
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, hresetn} = '0;
    errors = 0;
    tests_run = 0;
    v = $urandom(92);
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    bus(0, IX_CTRL, 0);
    `CHK("ctrl", 32'h00000803, rd)
    bus(0, IX_PORT, 0);
    `CHK("port", 32'h000001F6, rd)
    // Point 0 holds 1.0, mapped, healthy
    bus(1, IX_PTIDX, 0);
    bus(1, IX_PTLO, 32'h00010000);
    bus(1, IX_PTHI, 32'h20000000);
    tcp(16'h4E20, 16'h3F80, 0);
    tcp(16'h4E22, 16'h0000, 0);
    bus(1, IX_CTRL, 32'h883);
    tcp(16'h4E20, 16'h0000, 0);
    tcp(16'h4E21, 16'h3F80, 0);
    // Random whole value plus one half
    v = $urandom % 1000;
    bus(1, IX_PTLO, (v << 16) + 32'h8000);
    bus(1, IX_PTHI, 32'h20000000);
    bus(1, IX_CTRL, 32'h8A3);
    tcp(16'h4E21, 16'(v + 1), 0);
    bus(1, IX_OFS, 32'h5);
    bus(1, IX_CTRL, 32'h843);
    tcp(16'h4E21, 16'(v + 1 - 5 + 32768), 0);
    tcp(16'h4E20, 16'h0000, 0);
    // Per point gain 2.0, offset 0
    bus(1, IX_PTHI, 32'h22000000);
    bus(1, IX_CTRL, 32'h043);
    tcp(16'h4E21, 16'(2 * v + 1 + 32768), 0);
    bus(1, IX_SMAX, 32'h5);
    bus(0, IX_SMAX, 0);
    `CHK("smax", 32'h000003E7, rd)
    tcp(16'h4E21, 16'h03E7, 0);
    // Source error substitution
    bus(1, IX_PTHI, 32'h32000000);
    bus(1, IX_ERRI, 32'h1234);
    bus(1, IX_CTRL, 32'h143);
    tcp(16'h4E21, 16'h1234, 0);
    bus(1, IX_ERRF, 32'h4048F5C3);
    foreach (fe[k]) begin
      bus(1, IX_CTRL, 32'h103 | (k << 9));
      tcp(16'h4E20, fe[k], 0);
    end
    bus(1, IX_CTRL, 32'h813);
    tcp(16'h4E22, 16'h0000, 1);
    // Serial answers: divisor 8, 2 ms delay, random error word
    bus(1, IX_BAUD, 32'h8);
    bus(1, IX_DELAY, 32'h2);
    bus(1, IX_ERRI, 32'(v));
    rtu(12'h123, 8'h01, 16'h4E21, 16'(v), 0);
    rtu(12'h12D, 8'h01, 16'h4E21, 16'(v), 0);
    u_host.poll(1'b0, 8'h02, 16'h0, 16'h4E21, w, e, n);
    u_host.rx(8, 10, f, n);
    `CHK("no rtu", 1'b1, n >= 999)
    rtu(12'h018, 8'h77, 16'h4E22, 16'h0, 1);
    u_host.poll(1'b1, 8'h01, 16'h01F7, 16'h4E20, w, e, n);
    `CHK("no answer", 1'b1, n >= 99)
    end_sim();
  end
endmodule : modbus_sub_device_value_formatter_tb
